// ### design/sfr_pkg.sv
// Purpose: Constants and types for the synchronous fault status recorder.
// Assumes: One clock, APB register access, fault reports from core-side logic.
// Notes: Offsets are byte addresses on a 12-bit APB address.
// Notes on behaviour
// - Alternate access with space identifier 8 or 9 counts as instruction fault.
// - Fault class: 1 invalid, 2 protection, 3 privilege, 5 bus error.
// - Level field holds walk level 0 to 3 of the fault.
// - Instruction-recorded faults store access kind 2 or 3.
// - Single data fault: overwrite 0, address valid 1, data access kinds.
// - Instruction after pending instruction fault overwrites and sets overwrite.
// - Data after pending instruction fault replaces it, overwrite stays 0.
// - Instruction after pending data fault leaves the record alone.
// - Walk bus error, reserved entry or level-3 pointer gives class 4.
// - Translation fault stores its walk level and sets address valid.
// - Instruction translation after instruction fault overwrites, overwrite 1.
// - Instruction fault cannot replace pending instruction translation fault.
// - Translation fault cannot replace pending instruction translation fault.
// - Data fault cannot replace pending instruction translation fault.
// - Instruction translation after data fault overwrites, overwrite 1.
// - Data translation after instruction fault recorded with overwrite 0.
// - Nothing replaces a pending data translation fault.
// - Reading the status register clears all fault status bits.
// - Reset clears the status fields.
package sfr_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [11:0] ADDR_STATUS = 12'h000;
  localparam logic [11:0] ADDR_FADDR = 12'h004;
  localparam logic [11:0] ADDR_CTRL = 12'h008;

  // ----------------------------------------
  // Status field positions
  // ----------------------------------------
  localparam int ST_OW_BIT = 0;
  localparam int ST_FAV_BIT = 1;
  localparam int ST_FT_LSB = 2;
  localparam int ST_AT_LSB = 5;
  localparam int ST_LVL_LSB = 8;
  localparam int ST_BE_BIT = 10;
  localparam int ST_TO_BIT = 11;
  localparam int ST_UC_BIT = 12;

  // ----------------------------------------
  // Control fields and reset values
  // ----------------------------------------
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_STATE_LSB = 8;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [31:0] FADDR_RST = 32'h0000_0000;

  // ----------------------------------------
  // Codes
  // ----------------------------------------
  localparam logic [2:0] FT_NONE = 3'h0;
  localparam logic [2:0] FT_INVALID = 3'h1;
  localparam logic [2:0] FT_PROT = 3'h2;
  localparam logic [2:0] FT_PRIV = 3'h3;
  localparam logic [2:0] FT_XLAT = 3'h4;
  localparam logic [2:0] FT_BUS = 3'h5;
  localparam logic [1:0] ET_INVALID = 2'h0;
  localparam logic [1:0] ET_PTP = 2'h1;
  localparam logic [1:0] ET_RSVD = 2'h3;
  localparam logic [1:0] LVL_LAST = 2'h3;
  localparam logic [5:0] ASI_INSTR_USER = 6'h08;
  localparam logic [5:0] ASI_INSTR_SUPER = 6'h09;
  localparam logic [1:0] AT_INSTR_HI = 2'h1;

  // ----------------------------------------
  // Pending fault class
  // ----------------------------------------
  typedef enum logic [4:0] {
    SFR_IDLE = 5'h01,
    SFR_INSTR = 5'h02,
    SFR_DATA = 5'h04,
    SFR_TINSTR = 5'h08,
    SFR_TDATA = 5'h10
  } sfr_state_t;

endpackage

// ### design/sfr_fault_classify.sv
// Purpose: Picks the fault class code of one fault report by priority.
// Assumes: Inputs are stable in the cycle the report is valid.
// Notes: Translation beats invalid, privilege, protection, then bus error.
`timescale 1ns/10ps
module sfr_fault_classify (
  // Table walk result
  input wire logic tlb_hit,
  input wire logic [1:0] entry_kind_code,
  input wire logic [1:0] level,
  input wire logic walk_berr,
  // Access checks
  input wire logic prot_err,
  input wire logic priv_err,
  input wire logic uncorrectable_flag,
  input wire logic bus_expiry_flag,
  input wire logic bus_error_flag,
  // Result
  output logic [2:0] fault_class_code,
  output logic xlat
);

  logic table_pointer_entry;

  always_comb begin
    table_pointer_entry = !tlb_hit && (entry_kind_code == sfr_pkg::ET_PTP);
    xlat = walk_berr || (!tlb_hit && (entry_kind_code == sfr_pkg::ET_RSVD)) ||
           (table_pointer_entry && (level == sfr_pkg::LVL_LAST));
    if (xlat) begin
      fault_class_code = sfr_pkg::FT_XLAT;
    end else if (!tlb_hit && (entry_kind_code == sfr_pkg::ET_INVALID)) begin
      fault_class_code = sfr_pkg::FT_INVALID;
    end else if (priv_err) begin
      fault_class_code = sfr_pkg::FT_PRIV;
    end else if (prot_err) begin
      fault_class_code = sfr_pkg::FT_PROT;
    end else if (uncorrectable_flag || bus_expiry_flag || bus_error_flag) begin
      fault_class_code = sfr_pkg::FT_BUS;
    end else begin
      fault_class_code = sfr_pkg::FT_NONE;
    end
  end

endmodule // sfr_fault_classify

// ### design/sfr_recorder.sv
// Purpose: Records synchronous faults into status and address registers.
// Assumes: Fault reports come from logic on pclk; APB3 slave, no wait states.
// Notes: A status read clears in its setup cycle, so a fault in that cycle survives.
`timescale 1ns/10ps
module sfr_recorder (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Fault report from the core side
  input wire logic flt_valid,
  input wire logic flt_data_acc,
  input wire logic flt_alt,
  input wire logic [5:0] flt_asi,
  input wire logic flt_store,
  input wire logic flt_super,
  input wire logic flt_ispace,
  input wire logic [31:0] flt_addr,
  // Walk and check results
  input wire logic flt_tlb_hit,
  input wire logic [1:0] flt_entry_kind,
  input wire logic [1:0] flt_level,
  input wire logic flt_walk_berr,
  input wire logic flt_prot,
  input wire logic flt_priv,
  input wire logic flt_uc,
  input wire logic flt_to,
  input wire logic flt_be,
  // Status towards the core
  output logic fault_pending
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    sfr_pkg::sfr_state_t pend;
    logic pending;
    logic uncorrectable_flag;
    logic bus_expiry_flag;
    logic bus_error_flag;
    logic [2:0] fault_class_code;
    logic addr_valid_flag;
    logic fault_overwrite_flag;
    logic [2:0] access_kind_code;
    logic [1:0] level;
    logic [31:0] fault_address_reg;
    logic enable;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } sfr_regs_t;

  sfr_regs_t st_q;
  sfr_regs_t st_d;

  logic [2:0] new_ft;
  logic new_xlat;
  logic is_instr;
  logic fault_in;
  logic rd_clr;
  logic wr;
  logic new_ow;
  logic [2:0] new_at;
  sfr_pkg::sfr_state_t cls;
  sfr_pkg::sfr_state_t base;
  logic setup;

  // ----------------------------------------
  // Fault classification
  // ----------------------------------------
  sfr_fault_classify u_classify (
    .tlb_hit(flt_tlb_hit),
    .entry_kind_code(flt_entry_kind),
    .level(flt_level),
    .walk_berr(flt_walk_berr),
    .prot_err(flt_prot),
    .priv_err(flt_priv),
    .uncorrectable_flag(flt_uc),
    .bus_expiry_flag(flt_to),
    .bus_error_flag(flt_be),
    .fault_class_code(new_ft),
    .xlat(new_xlat)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    setup = psel && !penable;
    is_instr = !flt_data_acc || (flt_alt &&
               ((flt_asi == sfr_pkg::ASI_INSTR_USER) ||
                (flt_asi == sfr_pkg::ASI_INSTR_SUPER)));
    if (is_instr) begin
      new_at = {1'b0, sfr_pkg::AT_INSTR_HI[0], flt_super};
    end else begin
      new_at = {flt_store, flt_store && flt_ispace, flt_super};
    end
    if (new_xlat) begin
      cls = is_instr ? sfr_pkg::SFR_TINSTR : sfr_pkg::SFR_TDATA;
    end else begin
      cls = is_instr ? sfr_pkg::SFR_INSTR : sfr_pkg::SFR_DATA;
    end
    fault_in = flt_valid && st_q.enable && (new_ft != sfr_pkg::FT_NONE);
    rd_clr = setup && !pwrite && (paddr == sfr_pkg::ADDR_STATUS);
    // A read in the same cycle as a new fault sees the old record;
    // the new fault is then taken as a single fault so it is not lost.
    base = rd_clr ? sfr_pkg::SFR_IDLE : st_q.pend;
    wr = 1'b0;
    new_ow = 1'b0;
    if (rd_clr) begin
      st_d.pend = sfr_pkg::SFR_IDLE;
      st_d.pending = 1'b0;
      st_d.uncorrectable_flag = 1'b0;
      st_d.bus_expiry_flag = 1'b0;
      st_d.bus_error_flag = 1'b0;
      st_d.fault_class_code = sfr_pkg::FT_NONE;
      st_d.addr_valid_flag = 1'b0;
      st_d.fault_overwrite_flag = 1'b0;
      st_d.access_kind_code = 3'h0;
      st_d.level = 2'h0;
    end
    if (fault_in) begin
      case (base)
        sfr_pkg::SFR_IDLE: begin
          wr = 1'b1;
          new_ow = 1'b0;
        end
        sfr_pkg::SFR_INSTR: begin
          wr = 1'b1;
          new_ow = (cls == sfr_pkg::SFR_INSTR) ||
                   (cls == sfr_pkg::SFR_TINSTR);
        end
        sfr_pkg::SFR_DATA: begin
          // Data after data cannot come from the core; treated as overwrite
          wr = (cls != sfr_pkg::SFR_INSTR);
          new_ow = 1'b1;
        end
        sfr_pkg::SFR_TINSTR: begin
          wr = 1'b0;
        end
        sfr_pkg::SFR_TDATA: begin
          wr = 1'b0;
        end
        default: begin
          wr = 1'b0;
        end
      endcase
    end
    if (wr) begin
      st_d.pend = cls;
      st_d.pending = 1'b1;
      st_d.uncorrectable_flag = flt_uc;
      st_d.bus_expiry_flag = flt_to;
      st_d.bus_error_flag = flt_be;
      st_d.fault_class_code = new_ft;
      st_d.addr_valid_flag = 1'b1;
      st_d.fault_overwrite_flag = new_ow;
      st_d.access_kind_code = new_at;
      st_d.level = flt_level;
      st_d.fault_address_reg = flt_addr;
    end
    // APB: answer prepared in setup, pready shown in the access cycle
    st_d.pready = setup;
    if (setup) begin
      st_d.prdata = 32'h0000_0000;
      st_d.pslverr = 1'b0;
      case (paddr)
        sfr_pkg::ADDR_STATUS: begin
          st_d.prdata[sfr_pkg::ST_OW_BIT] = st_q.fault_overwrite_flag;
          st_d.prdata[sfr_pkg::ST_FAV_BIT] = st_q.addr_valid_flag;
          st_d.prdata[sfr_pkg::ST_FT_LSB +: 3] = st_q.fault_class_code;
          st_d.prdata[sfr_pkg::ST_AT_LSB +: 3] = st_q.access_kind_code;
          st_d.prdata[sfr_pkg::ST_LVL_LSB +: 2] = st_q.level;
          st_d.prdata[sfr_pkg::ST_BE_BIT] = st_q.bus_error_flag;
          st_d.prdata[sfr_pkg::ST_TO_BIT] = st_q.bus_expiry_flag;
          st_d.prdata[sfr_pkg::ST_UC_BIT] = st_q.uncorrectable_flag;
        end
        sfr_pkg::ADDR_FADDR: begin
          st_d.prdata = st_q.fault_address_reg;
        end
        sfr_pkg::ADDR_CTRL: begin
          st_d.prdata[sfr_pkg::CTRL_EN_BIT] = st_q.enable;
          st_d.prdata[sfr_pkg::CTRL_STATE_LSB +: 5] = st_q.pend;
        end
        default: begin
          st_d.pslverr = 1'b1;
        end
      endcase
    end
    if (psel && penable && st_q.pready && pwrite &&
        (paddr == sfr_pkg::ADDR_CTRL)) begin
      st_d.enable = pwdata[sfr_pkg::CTRL_EN_BIT];
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q.pend <= sfr_pkg::SFR_IDLE;
      st_q.pending <= 1'b0;
      st_q.uncorrectable_flag <= 1'b0;
      st_q.bus_expiry_flag <= 1'b0;
      st_q.bus_error_flag <= 1'b0;
      st_q.fault_class_code <= sfr_pkg::FT_NONE;
      st_q.addr_valid_flag <= 1'b0;
      st_q.fault_overwrite_flag <= 1'b0;
      st_q.access_kind_code <= 3'h0;
      st_q.level <= 2'h0;
      st_q.fault_address_reg <= sfr_pkg::FADDR_RST;
      st_q.enable <= sfr_pkg::CTRL_EN_RST;
      st_q.prdata <= 32'h0000_0000;
      st_q.pready <= 1'b0;
      st_q.pslverr <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign fault_pending = st_q.pending;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_asi_as_instr: assert property (
    (fault_in && base == sfr_pkg::SFR_IDLE && flt_data_acc && flt_alt &&
     flt_asi == sfr_pkg::ASI_INSTR_SUPER && !new_xlat)
    |=> (st_q.pend == sfr_pkg::SFR_INSTR) &&
        (st_q.access_kind_code == {2'h1, $past(flt_super)})
  ) else $error("alternate space 9 access not recorded as instruction");

  a_bus_code: assert property (
    (wr && flt_tlb_hit && !flt_walk_berr && !flt_prot && !flt_priv && flt_to)
    |=> st_q.fault_class_code == sfr_pkg::FT_BUS && st_q.bus_expiry_flag
  ) else $error("bus error fault class wrong");

  a_level_kept: assert property (
    wr |=> (st_q.level == $past(flt_level)) && st_q.addr_valid_flag
  ) else $error("walk level not recorded");

  a_instr_kind: assert property (
    (st_q.pend == sfr_pkg::SFR_INSTR) || (st_q.pend == sfr_pkg::SFR_TINSTR)
    |-> st_q.access_kind_code[2:1] == 2'h1
  ) else $error("instruction record with data access kind");

  a_single_data: assert property (
    (wr && base == sfr_pkg::SFR_IDLE && cls == sfr_pkg::SFR_DATA)
    |=> !st_q.fault_overwrite_flag && st_q.addr_valid_flag && fault_pending
  ) else $error("single data fault flags wrong");

  a_instr_overwrite: assert property (
    (fault_in && base == sfr_pkg::SFR_INSTR && cls == sfr_pkg::SFR_INSTR)
    |=> st_q.fault_overwrite_flag && st_q.fault_class_code == $past(new_ft)
  ) else $error("second instruction fault did not overwrite");

  a_data_replace: assert property (
    (fault_in && base == sfr_pkg::SFR_INSTR && !is_instr)
    |=> !st_q.fault_overwrite_flag && st_q.fault_address_reg == $past(flt_addr)
  ) else $error("data fault did not replace instruction fault");

  a_data_keeps: assert property (
    (fault_in && base == sfr_pkg::SFR_DATA && cls == sfr_pkg::SFR_INSTR)
    |=> $stable(st_q.fault_address_reg) && $stable(st_q.fault_overwrite_flag)
  ) else $error("instruction fault changed data record");

  a_xlat_class: assert property (
    (wr && flt_walk_berr) |=> st_q.fault_class_code == sfr_pkg::FT_XLAT
  ) else $error("walk bus error not class 4");

  a_xlat_over: assert property (
    (fault_in && cls == sfr_pkg::SFR_TINSTR &&
     (base == sfr_pkg::SFR_INSTR || base == sfr_pkg::SFR_DATA))
    |=> st_q.fault_overwrite_flag && st_q.pend == sfr_pkg::SFR_TINSTR
  ) else $error("instruction translation fault did not overwrite");

  a_xlat_keeps: assert property (
    (fault_in && (base == sfr_pkg::SFR_TINSTR || base == sfr_pkg::SFR_TDATA))
    |=> $stable(st_q.fault_address_reg) && $stable(st_q.fault_class_code) &&
        $stable(st_q.fault_overwrite_flag)
  ) else $error("translation record was replaced");

  a_read_clears: assert property (
    (rd_clr && !fault_in) |=> st_q.fault_class_code == sfr_pkg::FT_NONE &&
      !st_q.addr_valid_flag && !st_q.fault_overwrite_flag && pready
  ) else $error("status read did not clear");

  a_same_fault: assert property (
    wr |=> st_q.fault_address_reg == $past(flt_addr) && st_q.pend == $past(cls)
  ) else $error("address and status disagree");

  a_xlat_valid: assert property (
    (wr && new_xlat) |=> st_q.addr_valid_flag && st_q.level == $past(flt_level) &&
      st_q.fault_class_code == sfr_pkg::FT_XLAT
  ) else $error("translation fault not recorded with level");

  a_tinstr_holds: assert property (
    (fault_in && base == sfr_pkg::SFR_TINSTR && !new_xlat)
    |=> $stable(st_q.pend) && $stable(st_q.level) && $stable(st_q.fault_address_reg)
  ) else $error("fault replaced instruction translation record");

  a_data_xlat_ow: assert property (
    (fault_in && base == sfr_pkg::SFR_DATA && cls == sfr_pkg::SFR_TINSTR)
    |=> st_q.fault_overwrite_flag && st_q.fault_address_reg == $past(flt_addr)
  ) else $error("instruction translation fault did not replace data fault");

  a_instr_tdata: assert property (
    (fault_in && base == sfr_pkg::SFR_INSTR && cls == sfr_pkg::SFR_TDATA)
    |=> !st_q.fault_overwrite_flag && st_q.access_kind_code[2:1] != 2'h1
  ) else $error("data translation fault after instruction fault wrong");

  a_tdata_holds: assert property (
    (fault_in && base == sfr_pkg::SFR_TDATA && is_instr)
    |=> $stable(st_q.pend) && $stable(st_q.fault_address_reg) &&
        $stable(st_q.fault_overwrite_flag)
  ) else $error("instruction fault replaced data translation record");

  a_read_pending: assert property (
    (rd_clr && !fault_in) |=> !fault_pending && st_q.pend == sfr_pkg::SFR_IDLE
  ) else $error("status read left a record pending");

  c_double_instr: cover property (
    fault_in && base == sfr_pkg::SFR_INSTR && cls == sfr_pkg::SFR_INSTR);
  c_xlat_after_data: cover property (
    fault_in && base == sfr_pkg::SFR_DATA && cls == sfr_pkg::SFR_TINSTR);
  c_read_and_fault: cover property (rd_clr && fault_in);
  c_locked: cover property (fault_in && base == sfr_pkg::SFR_TDATA);
  c_instr_then_tdata: cover property (
    fault_in && base == sfr_pkg::SFR_INSTR && cls == sfr_pkg::SFR_TDATA);

endmodule // sfr_recorder

// ### test/sfr_tb_pkg.sv
// Purpose: Fault report record shared by the bench and the core model.
// Assumes: Field meanings follow the recorder's fault port.
// Notes: Packed so that one value drives the whole report.
package sfr_tb_pkg;
  typedef struct packed {
    logic dacc;
    logic alt;
    logic [5:0] asi;
    logic st;
    logic sup;
    logic isp;
    logic [31:0] addr;
    logic hit;
    logic [1:0] ek;
    logic [1:0] lvl;
    logic wbe;
    logic prot;
    logic priv;
    logic unc;
    logic tmo;
    logic berr;
  } sfr_flt_t;
endpackage

// ### test/sfr_core_model.sv
// Purpose: Core-side model that issues fault reports to the recorder.
// Assumes: Calls are made right after a rising edge of pclk.
// Notes: Between reports the fields carry the inverse of the last one.
`timescale 1ns/10ps
module sfr_core_model (
  // Clock
  input wire logic pclk,
  // Fault report
  output logic flt_valid,
  output sfr_tb_pkg::sfr_flt_t flt
);
  initial begin
    flt_valid = 1'b0;
    flt = '0;
  end

  // Valid stays up, so reports may follow back to back
  task automatic send(input sfr_tb_pkg::sfr_flt_t f);
    @(posedge pclk);
    flt_valid <= 1'b1;
    flt <= f;
  endtask

  // Fields are not held once valid drops
  task automatic idle();
    @(posedge pclk);
    flt_valid <= 1'b0;
    flt <= ~flt;
  endtask
endmodule // sfr_core_model

// ### test/sync_fault_status_recorder_test.sv
// Purpose: Self-checking bench for the fault status recorder.
// Assumes: Zero-wait APB slave; records visible the cycle after a report.
// Notes: Expected words are rebuilt here from the field layout.
`timescale 1ns/10ps
module sync_fault_status_recorder_test;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fault_pending, flt_valid, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] sq;
  sfr_tb_pkg::sfr_flt_t flt, f;
  int errors, checks_done;

  sfr_recorder i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flt_valid(flt_valid), .flt_data_acc(flt.dacc), .flt_alt(flt.alt),
    .flt_asi(flt.asi), .flt_store(flt.st), .flt_super(flt.sup), .flt_ispace(flt.isp),
    .flt_addr(flt.addr), .flt_tlb_hit(flt.hit), .flt_entry_kind(flt.ek),
    .flt_level(flt.lvl), .flt_walk_berr(flt.wbe), .flt_prot(flt.prot), .flt_priv(flt.priv),
    .flt_uc(flt.unc), .flt_to(flt.tmo), .flt_be(flt.berr), .fault_pending(fault_pending));
  sfr_core_model i_core (.pclk(pclk), .flt_valid(flt_valid), .flt(flt));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      errors++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Kinds: 0 invalid, 1 prot, 2 priv over prot, 3 bus, 4-6 walk faults, 7 none
  function automatic sfr_tb_pkg::sfr_flt_t mk(input logic d, input logic [2:0] k,
      input logic [1:0] l, input logic s);
    sfr_tb_pkg::sfr_flt_t r;
    r = '0;
    sq++;
    r.addr = {16'hC0DE, sq, 5'h00, k};
    r.dacc = d;
    r.st = d & s;
    r.sup = s ^ l[0];
    r.isp = l[1];
    r.lvl = l;
    case (k)
      3'h0: r.prot = 1'b1;
      3'h1: {r.hit, r.prot} = 2'h3;
      3'h2: {r.hit, r.priv, r.prot} = 3'h7;
      3'h3: {r.hit, r.unc, r.tmo, r.berr} = {2'h3, s, ~s};
      3'h4: {r.ek, r.wbe, r.priv} = 4'hB;
      3'h5: r.ek = 2'h3;
      3'h6: {r.ek, r.lvl} = 4'h7;
      default: {r.ek, r.lvl} = 4'h6;
    endcase
    return r;
  endfunction

  function automatic logic [31:0] exp_st(input sfr_tb_pkg::sfr_flt_t r, input logic ovw);
    logic [2:0] c;
    logic [2:0] acc;
    logic ins;
    ins = !r.dacc || (r.alt && (r.asi == 6'h08 || r.asi == 6'h09));
    acc = ins ? {2'h1, r.sup} : {r.st, r.st & r.isp, r.sup};
    if (!r.hit && (r.wbe || r.ek == 2'h3 || (r.ek == 2'h1 && r.lvl == 2'h3))) c = 3'h4;
    else if (!r.hit && r.ek == 2'h0) c = 3'h1;
    else if (r.priv) c = 3'h3;
    else if (r.prot) c = 3'h2;
    else if (r.unc | r.tmo | r.berr) c = 3'h5;
    else c = 3'h0;
    if (c == 3'h0) return 32'h0;
    return {19'h0, r.unc, r.tmo, r.berr, r.lvl, acc, c, 1'b1, ovw};
  endfunction

  function automatic logic [31:0] exp_ctl(input sfr_tb_pkg::sfr_flt_t r);
    logic [31:0] s;
    logic [4:0] p;
    s = exp_st(r, 1'b0);
    p = (s[7:6] == 2'h1) ? 5'h02 : 5'h04;
    if (s[4:2] == 3'h4) p = p << 2;
    return (s == 32'h0) ? 32'h0000_0101 : {19'h0, p, 8'h01};
  endfunction

  task automatic verify(input sfr_tb_pkg::sfr_flt_t r, input logic ovw);
    logic [31:0] e;
    e = exp_st(r, ovw);
    apb(1'b0, sfr_pkg::ADDR_FADDR, 32'h0);
    if (e != 32'h0) chk("address", rd, r.addr);
    chk("pending", {31'h0, fault_pending}, {31'h0, e != 32'h0});
    apb(1'b0, sfr_pkg::ADDR_CTRL, 32'h0);
    chk("class state", rd, exp_ctl(r));
    apb(1'b0, sfr_pkg::ADDR_STATUS, 32'h0);
    chk("status", rd, e);
    chk("pending clear", {31'h0, fault_pending}, 32'h0);
    apb(1'b0, sfr_pkg::ADDR_STATUS, 32'h0);
    chk("status clear", rd, 32'h0);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk("pending", {31'h0, fault_pending}, 32'h0);
    apb(1'b0, sfr_pkg::ADDR_STATUS, 32'h0);
    chk("status", rd, 32'h0);
    apb(1'b0, sfr_pkg::ADDR_FADDR, 32'h0);
    chk("address", rd, sfr_pkg::FADDR_RST);
    apb(1'b0, sfr_pkg::ADDR_CTRL, 32'h0);
    chk("control", rd, 32'h0000_0101);
    $display("test reset done");
  endtask

  task automatic t_single();
    for (int i = 0; i < 32; i++) begin
      f = mk(i[0], i[3:1], 2'(i / 3), i[4]);
      i_core.send(f);
      i_core.idle();
      verify(f, 1'b0);
    end
    for (int a = 8; a < 11; a++) begin
      f = mk(1'b1, 3'h1, 2'h0, a[0]);
      f.alt = 1'b1;
      f.asi = 6'(a);
      i_core.send(f);
      i_core.idle();
      verify(f, 1'b0);
    end
    $display("test single faults done");
  endtask

  // Kind nibble: bit0 data, bit1 translation, bit2 alternate space 8
  function automatic sfr_tb_pkg::sfr_flt_t fk(input logic [3:0] n, input logic [1:0] l,
      input logic s);
    sfr_tb_pkg::sfr_flt_t r;
    r = mk(n[0] | n[2], n[1] ? 3'h5 : {2'h0, n[0]} + 3'h1, l, s);
    r.alt = n[2];
    r.asi = n[2] ? 6'h08 : 6'h00;
    return r;
  endfunction

  task automatic t_pairs();
    sfr_tb_pkg::sfr_flt_t a, b;
    logic [15:0] tbl [15] = '{16'h0011, 16'h0110, 16'h1000, 16'h0211, 16'h0310,
      16'h1211, 16'h2000, 16'h2200, 16'h2300, 16'h2100, 16'h3000, 16'h3200,
      16'h4011, 16'h0411, 16'h1400};
    foreach (tbl[j]) begin
      a = fk(tbl[j][15:12], 2'h1, 1'b0);
      b = fk(tbl[j][11:8], 2'h2, 1'b1);
      i_core.send(a);
      i_core.send(b);
      i_core.idle();
      verify(tbl[j][4] ? b : a, tbl[j][0]);
    end
    $display("test fault pairs done");
  endtask

  task automatic t_regs();
    sfr_tb_pkg::sfr_flt_t g;
    apb(1'b0, 12'h00C, 32'h0);
    chk("unmapped error", {31'h0, err}, 32'h1);
    chk("unmapped data", rd, 32'h0);
    f = mk(1'b1, 3'h1, 2'h1, 1'b0);
    apb(1'b1, sfr_pkg::ADDR_CTRL, 32'h0);
    i_core.send(f);
    i_core.idle();
    apb(1'b0, sfr_pkg::ADDR_CTRL, 32'h0);
    chk("disabled", rd, 32'h0000_0100);
    apb(1'b1, sfr_pkg::ADDR_CTRL, 32'h1);
    i_core.send(f);
    i_core.idle();
    apb(1'b1, sfr_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
    chk("status write error", {31'h0, err}, 32'h0);
    verify(f, 1'b0);
    g = mk(1'b0, 3'h1, 2'h0, 1'b0);
    f = mk(1'b0, 3'h2, 2'h3, 1'b1);
    i_core.send(g);
    i_core.idle();
    // Clear and new fault on one edge: the new one stays, as a single fault
    fork
      begin
        i_core.send(f);
        i_core.idle();
      end
      apb(1'b0, sfr_pkg::ADDR_STATUS, 32'h0);
    join
    chk("status at clear", rd, exp_st(g, 1'b0));
    verify(f, 1'b0);
    i_core.send(f);
    i_core.idle();
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    $display("test registers done");
    t_reset();
  endtask

  initial begin
    errors = 0;
    checks_done = 0;
    sq = 8'h00;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_single();
    t_pairs();
    t_regs();
    conclude();
  end
endmodule // sync_fault_status_recorder_test
